// ### rtl/spp_fifo.v
// small synchronous fifo with valid/ready on both sides
// assumes one clock, synchronous active-low reset
`default_nettype none
module spp_fifo
#(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW    = 2
)
(
    input  wire             i_core_clk,
    input  wire             i_rst_b,
    input  wire             i_in_valid,
    output wire             o_in_ready,
    input  wire [WIDTH-1:0] i_in_data,
    output wire             o_out_valid,
    input  wire             i_out_ready,
    output wire [WIDTH-1:0] o_out_data
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0]    wr_q;
    reg [AW-1:0]    rd_q;
    reg [AW:0]      cnt_q;
    wire            push;
    wire            pop;
    assign o_in_ready  = (cnt_q != DEPTH[AW:0]);
    assign o_out_valid = (cnt_q != {(AW+1){1'b0}});
    assign o_out_data  = mem_q[rd_q];
    assign push = i_in_valid & o_in_ready;
    assign pop  = i_out_ready & o_out_valid;
    always @(posedge i_core_clk)
    begin
        if (push)
            mem_q[wr_q] <= i_in_data;
    end
    always @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                        : wr_q + 1'b1;
            if (pop)
                rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                        : rd_q + 1'b1;
            if (push && !pop)
                cnt_q <= cnt_q + 1'b1;
            else if (pop && !push)
                cnt_q <= cnt_q - 1'b1;
        end
    end
endmodule // spp_fifo
`default_nettype wire

// ### rtl/spp_port.v
// serial port: flags, clock config, rate divider, data buffering
// assumes the cpu special-register port on i_core_clk; pins asynchronous
// Functional notes
// - transfer-complete flag sets at the end of every byte, any mode
// - interrupt request while enabled and any of four flags is one
// - no flag is cleared by hardware; software writes zero to clear
// - data write while transmit buffer full sets collision, write dropped
// - master with select mode 01 and select low: fault, disable port
// - slave overrun keeps old byte, drops new one, sets overrun flag
// - phase zero samples on first clock edge, one on second edge
// - polarity zero idles clock low, one idles it high
// - rate register sets master clock only; ignored as slave
// - master bit rate is system clock over 2*(div+1), so at most half system clock
// - busy bit reads one while a transfer is in progress
// - slave-selected bit reads one only as slave with de-glitched select input low
// - data write loads tx buffer, starts master; read gives rx buffer
// - master-enable selects master; enabled without it is slave
// - 4-wire slave active while select low; counter reset on its fall
// - msb first; after eight bits byte goes to the receive buffer
`include "spp_regs.vh"
`default_nettype none
module spp_port
#(
    parameter FIFO_DEPTH = `SPP_FIFO_DEPTH
)
(
    input  wire       i_core_clk,
    input  wire       i_rst_b,
    input  wire [7:0] i_reg_addr,
    input  wire       i_reg_wr,
    input  wire       i_reg_rd,
    input  wire [7:0] i_reg_wdata,
    output reg  [7:0] o_reg_rdata,
    output wire       o_irq,
    input  wire       i_irq_en,
    input  wire       i_sck,
    output reg        o_sck,
    output reg        o_sck_oe,
    input  wire       i_mosi,
    output reg        o_mosi,
    output reg        o_mosi_oe,
    input  wire       i_miso,
    output reg        o_miso,
    output reg        o_miso_oe,
    input  wire       i_slave_select_n,
    output reg        o_slave_select_n,
    output reg        o_slave_select_n_oe
);
    // control/config registers
    reg       done_q, write_collision_flag_q, mode_fault_flag_q, ovrn_q, en_q, mst_q, pha_q, pol_q;
    reg [1:0] smd_q;
    reg [7:0] div_q;
    reg [7:0] rxbuf_q;
    reg       rxfull_q;
    reg [7:0] shift_q;
    reg [2:0] bits_q;
    reg       busy_q;
    reg       sh_loaded_q;
    reg [7:0] rate_cnt_q;
    reg       mclk_q;
    reg       edge_half_q;
    reg       in_q;
    reg       sck_prev_q;
    reg       ss_prev_q;
    wire      sck_s;
    wire      ss_s;
    wire      mosi_s;
    wire      miso_s;
    // transmit path through the fifo
    wire       tx_ready;
    wire       tx_valid;
    wire [7:0] tx_data;
    wire       tx_pop;
    wire       wr_dat = i_reg_wr && (i_reg_addr == `SPP_ADDR_DAT);
    wire       slave  = en_q && !mst_q;
    wire       four_w = (smd_q == `SPP_RST_SMD);
    wire       sel    = !four_w || !ss_s;
    wire       sl_act = slave && sel;
    spp_sync #(.RST_VAL(1'b0)) u_sck
    (
        .i_core_clk (i_core_clk),
        .i_rst_b    (i_rst_b),
        .i_async    (i_sck),
        .o_level    (sck_s)
    );
    spp_sync #(.RST_VAL(1'b1)) u_ss
    (
        .i_core_clk (i_core_clk),
        .i_rst_b    (i_rst_b),
        .i_async    (i_slave_select_n),
        .o_level    (ss_s)
    );
    spp_sync #(.RST_VAL(1'b0)) u_mosi
    (
        .i_core_clk (i_core_clk),
        .i_rst_b    (i_rst_b),
        .i_async    (i_mosi),
        .o_level    (mosi_s)
    );
    spp_sync #(.RST_VAL(1'b0)) u_miso
    (
        .i_core_clk (i_core_clk),
        .i_rst_b    (i_rst_b),
        .i_async    (i_miso),
        .o_level    (miso_s)
    );
    spp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(2)) u_tx
    (
        .i_core_clk  (i_core_clk),
        .i_rst_b     (i_rst_b),
        .i_in_valid  (wr_dat),
        .o_in_ready  (tx_ready),
        .i_in_data   (i_reg_wdata),
        .o_out_valid (tx_valid),
        .i_out_ready (tx_pop),
        .o_out_data  (tx_data)
    );
    // serial clock edges, in idle-relative terms
    wire sck_rel    = sck_s ^ pol_q;
    wire s_lead     = sl_act && sck_rel && !(sck_prev_q ^ pol_q);
    wire s_trail    = sl_act && !sck_rel && (sck_prev_q ^ pol_q);
    wire ss_fall    = ss_prev_q && !ss_s;
    // master half-period tick
    wire m_tick     = mst_q && en_q && busy_q && (rate_cnt_q == div_q);
    wire m_lead     = m_tick && !mclk_q;
    wire m_trail    = m_tick && mclk_q;
    wire lead       = m_lead | s_lead;
    wire trail      = m_trail | s_trail;
    // sample and shift edges per phase
    wire samp_e     = pha_q ? trail : lead;
    wire shift_e    = pha_q ? lead  : trail;
    wire in_bit     = mst_q ? miso_s : mosi_s;
    wire last_bit   = samp_e && (bits_q == 3'h7);
    // master ends after the trailing edge of the eighth bit
    wire m_end      = mst_q && (pha_q ? last_bit
                      : (m_trail && (bits_q == 3'h0) && edge_half_q));
    // load shifter from buffer when idle
    assign tx_pop   = tx_valid && !busy_q && !sh_loaded_q && en_q;
    wire tx_empty   = !tx_valid;
    wire start_m    = mst_q && en_q && sh_loaded_q && !busy_q;
    wire fault      = mst_q && en_q && four_w && !ss_s;
    wire ctl_wr     = i_reg_wr && (i_reg_addr == `SPP_ADDR_CTL);
    wire cfg_wr     = i_reg_wr && (i_reg_addr == `SPP_ADDR_CFG);
    assign o_irq    = i_irq_en && (done_q | write_collision_flag_q | mode_fault_flag_q | ovrn_q);
    always @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            done_q <= 1'b0; write_collision_flag_q <= 1'b0; mode_fault_flag_q <= 1'b0; ovrn_q <= 1'b0;
            en_q <= 1'b0; mst_q <= 1'b0; pha_q <= 1'b0; pol_q <= 1'b0;
            smd_q <= `SPP_RST_SMD;
            div_q <= `SPP_RST_DIV;
            rxbuf_q <= 8'h00; rxfull_q <= 1'b0;
            shift_q <= 8'h00; bits_q <= 3'h0; busy_q <= 1'b0;
            sh_loaded_q <= 1'b0; rate_cnt_q <= 8'h00; mclk_q <= 1'b0;
            edge_half_q <= 1'b0; sck_prev_q <= 1'b0; ss_prev_q <= 1'b1;
            in_q <= 1'b0;
        end
        else
        begin
            sck_prev_q <= sck_s;
            ss_prev_q  <= ss_s;
            // software writes: only zeros clear flags, sets win below
            if (ctl_wr)
            begin
                if (!i_reg_wdata[`SPP_CTL_DONE]) done_q <= 1'b0;
                if (!i_reg_wdata[`SPP_CTL_WRITE_COLLISION_FLAG]) write_collision_flag_q <= 1'b0;
                if (!i_reg_wdata[`SPP_CTL_MODE_FAULT_FLAG]) mode_fault_flag_q <= 1'b0;
                if (!i_reg_wdata[`SPP_CTL_OVRN]) ovrn_q <= 1'b0;
                smd_q <= i_reg_wdata[`SPP_CTL_SMD_HI:`SPP_CTL_SMD_LO];
                en_q  <= i_reg_wdata[`SPP_CTL_EN];
            end
            if (cfg_wr)
            begin
                mst_q <= i_reg_wdata[`SPP_CFG_MST];
                pha_q <= i_reg_wdata[`SPP_CFG_PHA];
                pol_q <= i_reg_wdata[`SPP_CFG_POL];
            end
            if (i_reg_wr && (i_reg_addr == `SPP_ADDR_DIV))
                div_q <= i_reg_wdata;
            if (wr_dat && !tx_ready)
                write_collision_flag_q <= 1'b1;
            if (i_reg_rd && (i_reg_addr == `SPP_ADDR_DAT))
                rxfull_q <= 1'b0;
            if (tx_pop)
            begin
                shift_q     <= tx_data;
                sh_loaded_q <= 1'b1;
            end
            // master divider: half period is div+1 cycles
            if (start_m)
            begin
                busy_q <= 1'b1;
                rate_cnt_q <= 8'h00;
                mclk_q <= 1'b0;
            end
            else if (mst_q && busy_q)
                rate_cnt_q <= m_tick ? 8'h00 : rate_cnt_q + 8'h01;
            if (m_tick)
                mclk_q <= !mclk_q;
            if (s_lead || s_trail)
                busy_q <= 1'b1;
            // 4-wire slave: framing by select line
            if (slave && four_w && (ss_fall || ss_s))
            begin
                bits_q <= 3'h0;
                edge_half_q <= 1'b0;
                if (ss_s)
                    busy_q <= 1'b0;
            end
            if (!en_q)
            begin
                bits_q <= 3'h0;
                busy_q <= 1'b0;
                mclk_q <= 1'b0;
            end
            if (samp_e)
            begin
                in_q    <= in_bit;
                bits_q  <= bits_q + 3'h1;
                edge_half_q <= 1'b1;
            end
            // outgoing bit changes on the opposite edge
            if (shift_e && (bits_q != 3'h0))
                shift_q <= {shift_q[6:0], in_q};
            if (last_bit)
            begin
                if (!mst_q)
                    busy_q <= 1'b0;
                sh_loaded_q <= 1'b0;
                done_q      <= 1'b1;
                if (slave && rxfull_q)
                    ovrn_q <= 1'b1;
                else
                begin
                    rxbuf_q  <= {shift_q[6:0], in_bit};
                    rxfull_q <= 1'b1;
                end
            end
            if (m_end)
            begin
                busy_q      <= 1'b0;
                mclk_q      <= 1'b0;
                edge_half_q <= 1'b0;
            end
            if (fault)
            begin
                mode_fault_flag_q <= 1'b1;
                mst_q  <= 1'b0;
                en_q   <= 1'b0;
                busy_q <= 1'b0;
            end
        end
    end
    // pin drive
    wire shifter_empty = !sh_loaded_q && !busy_q && tx_empty;
    always @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            o_sck <= 1'b0; o_sck_oe <= 1'b0;
            o_mosi <= 1'b0; o_mosi_oe <= 1'b0;
            o_miso <= 1'b0; o_miso_oe <= 1'b0;
            o_slave_select_n <= 1'b1; o_slave_select_n_oe <= 1'b0;
        end
        else
        begin
            o_sck     <= (mst_q ? mclk_q : 1'b0) ^ pol_q;
            o_sck_oe  <= en_q && mst_q;
            o_mosi    <= shift_q[7];
            o_mosi_oe <= en_q && mst_q;
            o_miso    <= shift_q[7];
            o_miso_oe <= sl_act;
            o_slave_select_n    <= smd_q[0];
            o_slave_select_n_oe <= en_q && smd_q[1];
        end
    end
    always @*
    begin
        case (i_reg_addr)
            `SPP_ADDR_CFG: o_reg_rdata = {busy_q, mst_q, pha_q, pol_q,
                                          slave && !ss_s,
                                          ss_s, shifter_empty, !rxfull_q};
            `SPP_ADDR_DIV: o_reg_rdata = div_q;
            `SPP_ADDR_DAT: o_reg_rdata = rxbuf_q;
            `SPP_ADDR_CTL: o_reg_rdata = {done_q, write_collision_flag_q, mode_fault_flag_q, ovrn_q,
                                          smd_q, tx_ready, en_q};
            default:       o_reg_rdata = 8'h00;
        endcase
    end
endmodule // spp_port
`default_nettype wire

// ### rtl/spp_regs.vh
// register offsets, field positions, reset values and the fifo depth
// for the serial port block; included by spp_port only
`ifndef SPP_REGS_VH
`define SPP_REGS_VH
`define SPP_ADDR_CFG      8'hA1
`define SPP_ADDR_DIV      8'hA2
`define SPP_ADDR_DAT      8'hA3
`define SPP_ADDR_CTL      8'hF8
// port_control_flags fields
`define SPP_CTL_DONE      7
`define SPP_CTL_WRITE_COLLISION_FLAG      6
`define SPP_CTL_MODE_FAULT_FLAG      5
`define SPP_CTL_OVRN      4
`define SPP_CTL_SMD_HI    3
`define SPP_CTL_SMD_LO    2
`define SPP_CTL_TXE       1
`define SPP_CTL_EN        0
// port_config_status fields
`define SPP_CFG_BUSY      7
`define SPP_CFG_MST       6
`define SPP_CFG_PHA       5
`define SPP_CFG_POL       4
`define SPP_CFG_SEL       3
`define SPP_CFG_PIN       2
`define SPP_CFG_SRE       1
`define SPP_CFG_RXE       0
// reset values and fifo depth
`define SPP_RST_SMD       2'h1
`define SPP_RST_DIV       8'h00
`define SPP_FIFO_DEPTH    4
`endif

// ### rtl/spp_sync.v
// three-stage synchroniser; change counts when stages two and three agree
// assumes a single clock domain on i_core_clk
`default_nettype none
module spp_sync
#(
    parameter RST_VAL = 1'b0
)
(
    input  wire i_core_clk,
    input  wire i_rst_b,
    input  wire i_async,
    output reg  o_level
);
    reg s1_q;
    reg s2_q;
    reg s3_q;
    always @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            s1_q    <= RST_VAL;
            s2_q    <= RST_VAL;
            s3_q    <= RST_VAL;
            o_level <= RST_VAL;
        end
        else
        begin
            s1_q <= i_async;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
                o_level <= s3_q;
        end
    end
endmodule // spp_sync
`default_nettype wire

// ### tb/spp_peer.sv
// far side: slave answering one byte, or master sending one
// sees resolved wire levels; phase 0, polarity 0
`default_nettype none
module spp_peer (
    input  wire logic i_sck,
    input  wire logic i_mosi,
    output var  logic o_sck,
    output var  logic o_mosi,
    output wire logic o_miso,
    output var  logic o_sel_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] tx_q;
    logic [7:0] rx_q;
    realtime    last_t;
    realtime    period;
    logic       armed = 1'b0;
    initial
    begin
        tx_q = 8'h3C;
        {o_sck, o_mosi, o_sel_n} = 3'b011;
    end
    assign o_miso = tx_q[7];
    // sample on rising edge, msb first
    always @(posedge i_sck)
    begin
        rx_q   <= {rx_q[6:0], i_mosi};
        armed  <= 1'b1;
        period <= $realtime - last_t;
        last_t <= $realtime;
    end
    // shift on falling edge; spent bits become a toggling pattern
    // the settling of the wire at power-up is no clock edge
    always @(negedge i_sck)
        if (armed)
            tx_q <= {tx_q[6:0], ~tx_q[0]};
    // 160 ns clock within the frame only
    task automatic xfer(input logic [7:0] b);
        o_sel_n = 1'b0;
        #100;
        for (int i = 7; i >= 0; i--)
        begin
            o_mosi = b[i];
            #80 o_sck = 1'b1;
            #80 o_sck = 1'b0;
        end
        #100 o_sel_n = 1'b1;
        o_mosi = ~o_mosi;
    endtask
    task automatic sel(input logic lvl);
        o_sel_n = lvl;
    endtask
endmodule // spp_peer
`default_nettype wire

// ### tb/spp_port_bench.sv
// self-checking bench for spp_port against the peer model
// 100 MHz core clock; register access by strobes and address
`default_nettype none
module spp_port_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk, rst_b, wr_en, rd_en, irq_en;
    logic [7:0] addr, wdata, v;
    wire  [7:0] rdata;
    wire        irq, d_sck, sck_oe, d_mosi, mosi_oe, d_miso, miso_oe;
    wire        d_ss, ss_oe, p_sck, p_mosi, p_miso, p_ss;
    wire        sck_w  = sck_oe ? d_sck : p_sck;
    wire        mosi_w = mosi_oe ? d_mosi : p_mosi;
    wire        miso_w = miso_oe ? d_miso : p_miso;
    wire        ss_w   = ss_oe ? d_ss : p_ss;
    int         error_cnt = 0;
    int         samples_checked = 0;
    int         cyc = 0;

    spp_port spp_port_inst (
        .i_core_clk(clk), .i_rst_b(rst_b), .i_reg_addr(addr),
        .i_reg_wr(wr_en), .i_reg_rd(rd_en), .i_reg_wdata(wdata),
        .o_reg_rdata(rdata), .o_irq(irq), .i_irq_en(irq_en),
        .i_sck(sck_w), .o_sck(d_sck), .o_sck_oe(sck_oe),
        .i_mosi(mosi_w), .o_mosi(d_mosi), .o_mosi_oe(mosi_oe),
        .i_miso(miso_w), .o_miso(d_miso), .o_miso_oe(miso_oe),
        .i_slave_select_n(ss_w), .o_slave_select_n(d_ss),
        .o_slave_select_n_oe(ss_oe));
    spp_peer spp_peer_inst (.i_sck(sck_w), .i_mosi(mosi_w),
        .o_sck(p_sck), .o_mosi(p_mosi), .o_miso(p_miso), .o_sel_n(p_ss));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        #1 v = rdata;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
    endtask
    task automatic rc(input logic [7:0] a, e, m);
        rd(a);
        chk(v & m, e);
    endtask
    task automatic wait_bit(input logic [7:0] a, input int b, input logic e);
        int n;
        n = 0;
        rd(a);
        while (v[b] !== e && n < 2000)
        begin
            rd(a);
            n++;
        end
        chk({7'h00, v[b]}, {7'h00, e});
    endtask

    initial
    begin
        {rst_b, wr_en, rd_en, irq_en} = 4'b0001;
        {addr, wdata} = 16'h0000;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        rc(8'hF8, 8'h06, 8'hFF);
        rc(8'hA1, 8'h07, 8'hFF);
        rc(8'hA2, 8'h00, 8'hFF);
        rc(8'h55, 8'h00, 8'hFF);
        wr(8'hF8, 8'h0D);
        rc(8'hF8, 8'h0F, 8'hFF);
        chk({6'h00, ss_oe, d_ss}, 8'h03);
        wr(8'hF8, 8'h09);
        rd(8'hF8);
        chk({6'h00, ss_oe, d_ss}, 8'h02);
        wr(8'hF8, 8'h01);
        wr(8'hA1, 8'h40);
        wr(8'hA2, 8'h07);
        wr(8'hA3, 8'hA5);
        wait_bit(8'hA1, 7, 1'b1);
        wait_bit(8'hF8, 7, 1'b1);
        wait_bit(8'hA1, 7, 1'b0);
        chk({7'h00, sck_w}, 8'h00);
        chk(spp_peer_inst.rx_q, 8'hA5);
        chk(8'(int'(spp_peer_inst.period)), 8'(2 * (7 + 1) * 10));
        chk({7'h00, irq}, 8'h01);
        @(posedge clk);
        irq_en <= 1'b0;
        #1 chk({7'h00, irq}, 8'h00);
        irq_en <= 1'b1;
        rc(8'hA3, 8'h3C, 8'hFF);
        wr(8'hF8, 8'h81);
        rc(8'hF8, 8'h80, 8'h80);
        wr(8'hF8, 8'h01);
        rc(8'hF8, 8'h03, 8'hFF);
        chk({7'h00, irq}, 8'h00);
        wr(8'hF8, 8'h00);
        wr(8'hA1, 8'h50);
        wr(8'hF8, 8'h01);
        rc(8'hA1, 8'h50, 8'hF0);
        chk({7'h00, sck_w}, 8'h01);
        wr(8'hF8, 8'h05);
        rd(8'hF8);
        spp_peer_inst.sel(1'b0);
        wait_bit(8'hF8, 5, 1'b1);
        rc(8'hF8, 8'h24, 8'hFD);
        rc(8'hA1, 8'h00, 8'h40);
        chk({7'h00, irq}, 8'h01);
        wr(8'hF8, 8'h04);
        spp_peer_inst.sel(1'b1);
        wr(8'hA1, 8'h00);
        wr(8'hA2, 8'hFF);
        wr(8'hF8, 8'h05);
        spp_peer_inst.xfer(8'h96);
        wait_bit(8'hF8, 7, 1'b1);
        repeat (8) @(posedge clk);
        rc(8'hA1, 8'h00, 8'h09);
        repeat (8) @(posedge clk);
        spp_peer_inst.xfer(8'h4B);
        wait_bit(8'hF8, 4, 1'b1);
        rc(8'hA3, 8'h96, 8'hFF);
        wr(8'hF8, 8'h04);
        wr(8'hA1, 8'h40);
        wr(8'hF8, 8'h01);
        for (int i = 0; i < 6; i++)
        begin
            @(posedge clk);
            addr  <= 8'hA3;
            wdata <= 8'(i);
            wr_en <= 1'b1;
        end
        @(posedge clk);
        wr_en <= 1'b0;
        rc(8'hF8, 8'h40, 8'h42);
        end_sim();
    end
endmodule // spp_port_bench
`default_nettype wire

// ### tb/spp_port_monitor.sv
// assertions on the serial port pins and register read side
// bound into spp_port; sees its ports only
`default_nettype none
module spp_port_chk (
    input wire logic       i_core_clk,
    input wire logic       i_rst_b,
    input wire logic [7:0] i_reg_addr,
    input wire logic       i_reg_wr,
    input wire logic [7:0] o_reg_rdata,
    input wire logic       o_irq,
    input wire logic       i_irq_en,
    input wire logic       o_sck,
    input wire logic       o_sck_oe,
    input wire logic       o_mosi_oe,
    input wire logic       o_miso_oe,
    input wire logic       i_slave_select_n,
    input wire logic       o_slave_select_n,
    input wire logic       o_slave_select_n_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_b);
    wire logic ctl = i_reg_addr == 8'hF8;
    wire logic cfg = i_reg_addr == 8'hA1;
    sequence s_idle;
        cfg && o_sck_oe && !o_reg_rdata[7];
    endsequence
    sequence s_unsel;
        ctl && o_reg_rdata[3:2] == 2'b01 && i_slave_select_n;
    endsequence
    a_irq_flags:
    assert property (ctl |-> o_irq == (i_irq_en && |o_reg_rdata[7:4]))
        else $error("irq does not match flags");
    a_flags_held:
    assert property (ctl && $past(ctl) && !$past(i_reg_wr)
        |-> (o_reg_rdata[7:4] & $past(o_reg_rdata[7:4]))
            == $past(o_reg_rdata[7:4]))
        else $error("flag cleared without a write");
    a_master_pins:
    assert property (o_sck_oe == o_mosi_oe && !(o_sck_oe && o_miso_oe))
        else $error("pin drive does not match role");
    a_sck_idle:
    assert property (s_idle [*3] |-> o_sck == o_reg_rdata[4])
        else $error("serial clock not at idle level");
    a_select_drive:
    assert property (ctl && !$past(i_reg_wr) && o_slave_select_n_oe
        |-> o_reg_rdata[3] && o_slave_select_n == o_reg_rdata[2])
        else $error("select output wrong");
    a_fault_release:
    assert property ($fell(i_slave_select_n) && o_sck_oe && ctl
        && o_reg_rdata[3:2] == 2'b01 |-> ##[1:12] !o_sck_oe)
        else $error("master kept the clock after fault");
    a_slave_unsel:
    assert property ((cfg && !o_sck_oe && i_slave_select_n) [*6]
        |-> !o_reg_rdata[3])
        else $error("selected bit set while deselected");
    a_miso_free:
    assert property (s_unsel [*6] |-> !o_miso_oe)
        else $error("data out driven while deselected");
endmodule // spp_port_chk
bind spp_port spp_port_chk spp_port_chk_inst (.i_core_clk, .i_rst_b,
    .i_reg_addr, .i_reg_wr, .o_reg_rdata, .o_irq, .i_irq_en, .o_sck,
    .o_sck_oe, .o_mosi_oe, .o_miso_oe, .i_slave_select_n,
    .o_slave_select_n, .o_slave_select_n_oe);
`default_nettype wire
